// [core/tabc_ctrl.sv]
`timescale 1ns/1ns
`include "tabc_regs.svh"

// How it works
// - Each filter pole has a two-bit frequency code 00, 01, 10 and its own enable.
// - Gain field offers only 0.4, 2 and 10; illegal code writes are ignored.
// - Filter bypass bit switches the anti-aliasing filter off.
// - High-impedance bit in converter control tristates the conditioned pin driver.
// - Continuous mode converts every base period times two to the power N.
// - Conversions run repeatedly in continuous mode or once per written request.
// - The system clock steps the approximation one result bit per cycle.
// - Busy is high throughout a conversion and readable in converter control.
// - On completion data ready sets and the result registers load.
// - Reading the upper byte freezes the result until the lower byte is read.
// - A three-bit position code selects one input per bank for all comparators.
// - Comparator outputs are sampled in the cycle the status register is read.
// - Shared threshold comes from an 8-bit code, writable and readable.
// - Fixed comparators use internal or external threshold and drive eight outputs.
// - Current DAC takes a 10-bit code; complementary output carries the remainder.
// - Setting override select makes host-written trims replace defaults.
// - Clearing override select restores default trims into the trim register.
// - Readback select makes trim reads return the default stored bits.
// - With converter enable low no conversion starts and any running one stops.
module tabc_ctrl #(
  parameter int ADC_W           = 12,
  parameter int CNT_W           = 24,
  parameter int BASE_PERIOD_CYC = 64,
  parameter int TRIM_W          = 32
) (
  // Clock and reset.
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave.
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Converter path.
  input  wire logic                 sar_compare_in,
  output logic                      sar_sample,
  output logic [ADC_W-1:0]          sar_trial_code,
  output tabc_pkg::tabc_cond_s      cond,
  // Bi-level comparators.
  input  wire logic [7:0]           comparator_result_bit,
  input  wire logic [7:0]           fixed_comparator_in,
  output tabc_pkg::tabc_bl_s        bl,
  output logic [7:0]                fixed_comparator_output,
  // Current DAC.
  output logic [9:0]                current_dac_code,
  output logic [9:0]                current_dac_code_n,
  // Trim.
  input  wire logic [TRIM_W-1:0]    trim_default,
  output logic [TRIM_W-1:0]         trim_value
);
  import tabc_pkg::*;

  localparam int IDX_W = $clog2(ADC_W);
  localparam int HI_W  = ADC_W - 8;

  // ============================================================
  // State.
  typedef struct packed {
    tabc_cond_s        cond;
    logic [2:0]        rate;
    logic              cont;
    logic              start_pend;
    tabc_sar_e         sar;
    logic [IDX_W-1:0]  bit_idx;
    logic [ADC_W-1:0]  trial;
    logic              sample;
    logic              busy;
    logic              ready;
    logic [ADC_W-1:0]  result;
    logic              frozen;
    logic              pend_valid;
    logic [ADC_W-1:0]  pend;
    logic [CNT_W-1:0]  ivl_cnt;
    tabc_bl_s          bl;
    logic [7:0]        fixed_out;
    logic [9:0]        idac;
    logic [9:0]        idac_n;
    logic              trim_ovr_sel;
    logic              trim_rdb_sel;
    logic [TRIM_W-1:0] trim_ovr;
    logic [TRIM_W-1:0] trim_val;
    logic              dp_valid;
    logic [7:0]        dp_addr;
    logic [31:0]       hrdata;
  } tabc_state_s;

  tabc_state_s state_ff;
  tabc_state_s nxt_state;

  // ============================================================
  // Helpers.
  function automatic logic tabc_at(input logic [7:0] addr, input logic [7:0] off);
    tabc_at = (addr == off);
  endfunction : tabc_at

  function automatic logic [CNT_W-1:0] tabc_interval(input logic [2:0] n);
    tabc_interval = CNT_W'(BASE_PERIOD_CYC) << n;
  endfunction : tabc_interval

  function automatic logic tabc_legal(input logic [1:0] code);
    tabc_legal = (code != `TABC_CODE_ILLEGAL);
  endfunction : tabc_legal

  // ============================================================
  // Next state.
  logic             take;
  logic             trigger;
  logic             done;
  logic [ADC_W-1:0] decided;
  logic [7:0]       a_addr;
  logic             wr;

  always_comb begin
    nxt_state = state_ff;
    take      = hsel & htrans[1] & hready;
    a_addr    = haddr[7:0];
    trigger   = 1'b0;
    done      = 1'b0;
    decided   = state_ff.trial;
    wr        = state_ff.dp_valid;

    // ============================================================
    // Data phase of a write.
    if (wr) begin
      unique case (state_ff.dp_addr)
        `TABC_OFF_COND: begin
          if (tabc_legal(hwdata[`TABC_POLE1_LSB+:2])) begin
            nxt_state.cond.pole1_freq = hwdata[`TABC_POLE1_LSB+:2];
          end
          if (tabc_legal(hwdata[`TABC_POLE2_LSB+:2])) begin
            nxt_state.cond.pole2_freq = hwdata[`TABC_POLE2_LSB+:2];
          end
          nxt_state.cond.pole1_en = hwdata[`TABC_POLE1_EN_BIT];
          nxt_state.cond.pole2_en = hwdata[`TABC_POLE2_EN_BIT];
          if (tabc_legal(hwdata[`TABC_GAIN_LSB+:2])) begin
            nxt_state.cond.gain = tabc_gain_e'(hwdata[`TABC_GAIN_LSB+:2]);
          end
          nxt_state.cond.filter_bypass = hwdata[`TABC_BYPASS_BIT];
        end
        `TABC_OFF_ADC_CTRL: begin
          nxt_state.rate                      = hwdata[`TABC_RATE_LSB+:3];
          nxt_state.cont                      = hwdata[`TABC_CONT_BIT];
          nxt_state.cond.drive_high_impedance = hwdata[`TABC_HIZ_BIT];
          nxt_state.cond.adc_power_enable     = hwdata[`TABC_ADC_EN_BIT];
          // A start while busy is dropped rather than queued, so one write never yields two conversions.
          if (hwdata[`TABC_START_BIT] && !state_ff.busy) begin
            nxt_state.start_pend = 1'b1;
          end
        end
        `TABC_OFF_BL_CTRL: begin
          nxt_state.bl.position                  = hwdata[`TABC_POS_LSB+:3];
          nxt_state.bl.threshold_switch_enable   = hwdata[`TABC_SWEN_BIT];
          nxt_state.bl.external_threshold_select = hwdata[`TABC_EXTSEL_BIT];
        end
        `TABC_OFF_BL_DAC: begin
          nxt_state.bl.threshold_code = hwdata[7:0];
        end
        `TABC_OFF_IDAC: begin
          nxt_state.idac   = hwdata[9:0];
          nxt_state.idac_n = `TABC_IDAC_FULL - hwdata[9:0];
        end
        `TABC_OFF_TRIM_CTRL: begin
          nxt_state.trim_ovr_sel = hwdata[`TABC_OVR_BIT];
          nxt_state.trim_rdb_sel = hwdata[`TABC_RDB_BIT];
          if (!hwdata[`TABC_OVR_BIT]) begin
            nxt_state.trim_ovr = trim_default;
          end
        end
        `TABC_OFF_TRIM: begin
          nxt_state.trim_ovr = hwdata[TRIM_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // ============================================================
    // Address phase: capture writes, answer reads.
    nxt_state.dp_valid = take & hwrite;
    nxt_state.dp_addr  = a_addr;
    nxt_state.hrdata   = 32'h0000_0000;
    if (take && !hwrite) begin
      if (tabc_at(a_addr, `TABC_OFF_COND)) begin
        nxt_state.hrdata[`TABC_POLE1_LSB+:2]   = state_ff.cond.pole1_freq;
        nxt_state.hrdata[`TABC_POLE1_EN_BIT]   = state_ff.cond.pole1_en;
        nxt_state.hrdata[`TABC_POLE2_LSB+:2]   = state_ff.cond.pole2_freq;
        nxt_state.hrdata[`TABC_POLE2_EN_BIT]   = state_ff.cond.pole2_en;
        nxt_state.hrdata[`TABC_GAIN_LSB+:2]    = state_ff.cond.gain;
        nxt_state.hrdata[`TABC_BYPASS_BIT]     = state_ff.cond.filter_bypass;
      end
      if (tabc_at(a_addr, `TABC_OFF_ADC_CTRL)) begin
        nxt_state.hrdata[`TABC_RATE_LSB+:3]    = state_ff.rate;
        nxt_state.hrdata[`TABC_CONT_BIT]       = state_ff.cont;
        nxt_state.hrdata[`TABC_START_BIT]      = state_ff.start_pend;
        nxt_state.hrdata[`TABC_HIZ_BIT]        = state_ff.cond.drive_high_impedance;
        nxt_state.hrdata[`TABC_ADC_EN_BIT]     = state_ff.cond.adc_power_enable;
        nxt_state.hrdata[`TABC_BUSY_BIT]       = state_ff.busy;
        nxt_state.hrdata[`TABC_READY_BIT]      = state_ff.ready;
      end
      if (tabc_at(a_addr, `TABC_OFF_RES_HI)) begin
        // Freezing keeps a conversion that ends between the two byte reads out of the pair.
        nxt_state.hrdata[HI_W-1:0] = state_ff.result[ADC_W-1:8];
        nxt_state.frozen           = 1'b1;
      end
      if (tabc_at(a_addr, `TABC_OFF_RES_LO)) begin
        nxt_state.hrdata[7:0] = state_ff.result[7:0];
        nxt_state.frozen      = 1'b0;
        nxt_state.ready       = 1'b0;
        if (state_ff.pend_valid) begin
          nxt_state.result     = state_ff.pend;
          nxt_state.pend_valid = 1'b0;
        end
      end
      if (tabc_at(a_addr, `TABC_OFF_BL_CTRL)) begin
        nxt_state.hrdata[`TABC_POS_LSB+:3]   = state_ff.bl.position;
        nxt_state.hrdata[`TABC_SWEN_BIT]     = state_ff.bl.threshold_switch_enable;
        nxt_state.hrdata[`TABC_EXTSEL_BIT]   = state_ff.bl.external_threshold_select;
      end
      if (tabc_at(a_addr, `TABC_OFF_BL_STAT)) begin
        nxt_state.hrdata[7:0] = comparator_result_bit;
      end
      if (tabc_at(a_addr, `TABC_OFF_BL_DAC)) begin
        nxt_state.hrdata[7:0] = state_ff.bl.threshold_code;
      end
      if (tabc_at(a_addr, `TABC_OFF_IDAC)) begin
        nxt_state.hrdata[9:0] = state_ff.idac;
      end
      if (tabc_at(a_addr, `TABC_OFF_TRIM_CTRL)) begin
        nxt_state.hrdata[`TABC_OVR_BIT] = state_ff.trim_ovr_sel;
        nxt_state.hrdata[`TABC_RDB_BIT] = state_ff.trim_rdb_sel;
      end
      if (tabc_at(a_addr, `TABC_OFF_TRIM)) begin
        nxt_state.hrdata[TRIM_W-1:0] = state_ff.trim_rdb_sel ? trim_default : state_ff.trim_ovr;
      end
    end

    // ============================================================
    // Continuous interval timer.
    if (state_ff.cond.adc_power_enable && state_ff.cont) begin
      if (state_ff.ivl_cnt >= tabc_interval(state_ff.rate) - CNT_W'(1)) begin
        nxt_state.ivl_cnt = '0;
        trigger           = 1'b1;
      end else begin
        nxt_state.ivl_cnt = state_ff.ivl_cnt + CNT_W'(1);
      end
    end else begin
      nxt_state.ivl_cnt = '0;
    end
    if (state_ff.start_pend) begin
      trigger = 1'b1;
    end

    // ============================================================
    // Successive approximation sequencer.
    nxt_state.sample = 1'b0;
    unique case (state_ff.sar)
      TABC_IDLE: begin
        if (trigger && state_ff.cond.adc_power_enable) begin
          nxt_state.sar        = TABC_SAMPLE;
          nxt_state.busy       = 1'b1;
          nxt_state.sample     = 1'b1;
          nxt_state.start_pend = 1'b0;
        end
      end
      TABC_SAMPLE: begin
        nxt_state.sar     = TABC_CONVERT;
        nxt_state.trial   = ADC_W'(1) << (ADC_W - 1);
        nxt_state.bit_idx = IDX_W'(ADC_W - 1);
      end
      TABC_CONVERT: begin
        if (!sar_compare_in) begin
          decided[state_ff.bit_idx] = 1'b0;
        end
        nxt_state.trial = decided;
        if (state_ff.bit_idx == '0) begin
          done           = 1'b1;
          nxt_state.sar  = TABC_IDLE;
          nxt_state.busy = 1'b0;
        end else begin
          nxt_state.bit_idx                        = state_ff.bit_idx - IDX_W'(1);
          nxt_state.trial[state_ff.bit_idx - IDX_W'(1)] = 1'b1;
        end
      end
    endcase

    // ============================================================
    // Completion: set wins over the clear by a lower-byte read.
    if (done) begin
      nxt_state.ready = 1'b1;
      if (nxt_state.frozen) begin
        nxt_state.pend       = decided;
        nxt_state.pend_valid = 1'b1;
      end else begin
        nxt_state.result     = decided;
        nxt_state.pend_valid = 1'b0;
      end
    end

    // ============================================================
    // Converter disabled: abort and idle.
    if (!state_ff.cond.adc_power_enable) begin
      nxt_state.sar        = TABC_IDLE;
      nxt_state.busy       = 1'b0;
      nxt_state.start_pend = 1'b0;
      nxt_state.sample     = 1'b0;
    end

    // Fixed comparator results pass through one flop so each output is free of glitches.
    nxt_state.fixed_out = fixed_comparator_in;
    nxt_state.trim_val  = nxt_state.trim_ovr_sel ? nxt_state.trim_ovr : trim_default;
  end

  // ============================================================
  // Registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff                              <= '0;
      state_ff.cond.pole1_freq              <= `TABC_RST_POLE;
      state_ff.cond.pole2_freq              <= `TABC_RST_POLE;
      state_ff.cond.gain                    <= TABC_GAIN_0P4;
      state_ff.rate                         <= `TABC_RST_RATE;
      state_ff.sar                          <= TABC_IDLE;
      state_ff.bl.position                  <= `TABC_RST_POS;
      state_ff.bl.threshold_code            <= `TABC_RST_BL_DAC;
      state_ff.idac                         <= `TABC_RST_IDAC;
      state_ff.idac_n                       <= `TABC_IDAC_FULL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ============================================================
  // Outputs.
  // Zero wait states: every transfer ends in one data phase and is always OKAY.
  logic hreadyout_ff;
  logic hresp_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  assign hreadyout               = hreadyout_ff;
  assign hresp                   = hresp_ff;
  assign hrdata                  = state_ff.hrdata;
  assign sar_sample              = state_ff.sample;
  assign sar_trial_code          = state_ff.trial;
  assign cond                    = state_ff.cond;
  assign bl                      = state_ff.bl;
  assign fixed_comparator_output = state_ff.fixed_out;
  assign current_dac_code        = state_ff.idac;
  assign current_dac_code_n      = state_ff.idac_n;
  assign trim_value              = state_ff.trim_val;

endmodule : tabc_ctrl

// [core/tabc_regs.svh]
`ifndef TABC_REGS_SVH
`define TABC_REGS_SVH

// ============================================================
// Register byte offsets.
`define TABC_OFF_COND      8'h00
`define TABC_OFF_ADC_CTRL  8'h04
`define TABC_OFF_RES_HI    8'h08
`define TABC_OFF_RES_LO    8'h0C
`define TABC_OFF_BL_CTRL   8'h10
`define TABC_OFF_BL_STAT   8'h14
`define TABC_OFF_BL_DAC    8'h18
`define TABC_OFF_IDAC      8'h1C
`define TABC_OFF_TRIM_CTRL 8'h20
`define TABC_OFF_TRIM      8'h24

// ============================================================
// Conditioning register fields.
`define TABC_POLE1_LSB     0
`define TABC_POLE1_EN_BIT  2
`define TABC_POLE2_LSB     3
`define TABC_POLE2_EN_BIT  5
`define TABC_GAIN_LSB      6
`define TABC_BYPASS_BIT    8
`define TABC_CODE_ILLEGAL  2'h3

// ============================================================
// Converter control register fields.
`define TABC_RATE_LSB      0
`define TABC_CONT_BIT      3
`define TABC_START_BIT     4
`define TABC_HIZ_BIT       5
`define TABC_ADC_EN_BIT    6
`define TABC_BUSY_BIT      8
`define TABC_READY_BIT     9

// ============================================================
// Bi-level and trim control fields.
`define TABC_POS_LSB       0
`define TABC_SWEN_BIT      3
`define TABC_EXTSEL_BIT    4
`define TABC_OVR_BIT       0
`define TABC_RDB_BIT       1

// ============================================================
// Reset values.
`define TABC_RST_POLE      2'h0
`define TABC_RST_RATE      3'h0
`define TABC_RST_POS       3'h0
`define TABC_RST_BL_DAC    8'h00
`define TABC_RST_IDAC      10'h000
`define TABC_IDAC_FULL     10'h3FF

`endif

// [core/tabc_pkg.sv]
package tabc_pkg;

  // ============================================================
  // Converter sequencer states.
  typedef enum logic [2:0] {
    TABC_IDLE    = 3'b001,
    TABC_SAMPLE  = 3'b010,
    TABC_CONVERT = 3'b100
  } tabc_sar_e;

  // ============================================================
  // Amplifier gain codes.
  typedef enum logic [1:0] {
    TABC_GAIN_0P4 = 2'b00,
    TABC_GAIN_2   = 2'b01,
    TABC_GAIN_10  = 2'b10
  } tabc_gain_e;

  // ============================================================
  // Signal conditioning controls.
  typedef struct packed {
    logic [1:0] pole1_freq;
    logic       pole1_en;
    logic [1:0] pole2_freq;
    logic       pole2_en;
    tabc_gain_e gain;
    logic       filter_bypass;
    logic       drive_high_impedance;
    logic       adc_power_enable;
  } tabc_cond_s;

  // ============================================================
  // Bi-level controls.
  typedef struct packed {
    logic [2:0] position;
    logic       threshold_switch_enable;
    logic       external_threshold_select;
    logic [7:0] threshold_code;
  } tabc_bl_s;

endpackage : tabc_pkg

// [testbench/tabc_ctrl_assertions.sv]
`timescale 1ns/1ns
// ============================================================
// Port checker for the converter control block.
module tabc_ctrl_assertions
  import tabc_pkg::*;
#(
  parameter int ADC_W = 12
) (
  // Clock and reset.
  input wire logic             hclk,
  input wire logic             hresetn,
  // Register bus.
  input wire logic             hsel,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  // Converter, comparators and current DAC.
  input wire logic             sar_sample,
  input wire logic [ADC_W-1:0] sar_trial_code,
  input tabc_pkg::tabc_cond_s  cond,
  input tabc_pkg::tabc_bl_s    bl,
  input wire logic [7:0]       fixed_comparator_in,
  input wire logic [7:0]       fixed_comparator_output,
  input wire logic [9:0]       current_dac_code,
  input wire logic [9:0]       current_dac_code_n
);
  logic rd_dp_ff;
  logic wr_dp_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Tracks which kind of data phase is running.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp_ff <= 1'b0;
      wr_dp_ff <= 1'b0;
    end else begin
      rd_dp_ff <= hsel && htrans[1] && hready && !hwrite;
      wr_dp_ff <= hsel && htrans[1] && hready && hwrite;
    end
  end

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_RDATA_IDLE: assert property (!rd_dp_ff |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  AST_POLE_LEGAL: assert property (cond.pole1_freq != 2'h3 && cond.pole2_freq != 2'h3)
    else $error("pole code out of range");
  AST_GAIN_LEGAL: assert property (cond.gain != 2'h3)
    else $error("gain code out of range");
  AST_MSB_FIRST: assert property (sar_sample |=> sar_trial_code == {1'b1, {(ADC_W-1){1'b0}}})
    else $error("first trial is not the top bit");
  AST_BUSY_SPAN: assert property (sar_sample |=> !sar_sample [*8])
    else $error("new conversion while busy");
  AST_OFF_IDLE: assert property (!cond.adc_power_enable && !$past(cond.adc_power_enable) |-> !sar_sample)
    else $error("conversion while converter off");
  AST_BL_BY_WRITE: assert property ($changed(bl) |-> $past(wr_dp_ff))
    else $error("bi-level control changed without a write");
  AST_FIXED_FOLLOW: assert property ($past(hresetn) |-> fixed_comparator_output == $past(fixed_comparator_in))
    else $error("fixed output does not follow its input");
  AST_DAC_PAIR: assert property (current_dac_code_n == 10'h3FF - current_dac_code)
    else $error("complementary code wrong");

  COV_SAMPLE: cover property (sar_sample);
  COV_HIZ: cover property (cond.drive_high_impedance);
  COV_BL_CODE: cover property ($changed(bl.threshold_code));
endmodule : tabc_ctrl_assertions

// [testbench/tabc_analog_model.sv]
`timescale 1ns/1ns
// ============================================================
// Converter comparator: high while the input level reaches the trial code.
module tabc_analog_model #(
  parameter int ADC_W = 12
) (
  // Trial side.
  input  wire logic [ADC_W-1:0] sar_trial_code,
  input  wire logic [ADC_W-1:0] level,
  output logic                  sar_compare_in
);
  assign sar_compare_in = (level >= sar_trial_code);
endmodule : tabc_analog_model

// [testbench/telemetry_adc_bilevel_ctrl_bench.sv]
`timescale 1ns/1ns
`include "tabc_regs.svh"
// ============================================================
// Self-checking bench for the converter control block.
module telemetry_adc_bilevel_ctrl_bench;
  import tabc_pkg::*;
  localparam int BASE = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hreadyout, hresp, sar_compare_in, sar_sample, rd_dp = 1'b0;
  logic [31:0] hrdata, trim_val, trim_def = '0;
  logic [11:0] sar_trial_code, level = '0;
  logic [7:0]  cmp_bits = '0, fix_in = '0, fix_out;
  logic [9:0]  dac, dac_n;
  tabc_cond_s  cond;
  tabc_bl_s    bl;
  logic [31:0] exp_q[$];
  int          n_errors = 0, tests_run = 0, cyc = 0, n_samp = 0, t0 = 0, t1 = 0;

  tabc_ctrl #(.BASE_PERIOD_CYC(BASE)) u_tabc_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sar_compare_in(sar_compare_in), .sar_sample(sar_sample),
    .sar_trial_code(sar_trial_code), .cond(cond), .comparator_result_bit(cmp_bits),
    .fixed_comparator_in(fix_in), .bl(bl), .fixed_comparator_output(fix_out),
    .current_dac_code(dac), .current_dac_code_n(dac_n), .trim_default(trim_def), .trim_value(trim_val));
  tabc_analog_model u_tabc_analog_model (
    .sar_trial_code(sar_trial_code), .level(level), .sar_compare_in(sar_compare_in));

  always #25 hclk = ~hclk;

  // Sample pulse counter and read data watcher.
  always @(posedge hclk) begin
    cyc++;
    if (sar_sample === 1'b1) begin
      n_samp++;
      t0 = t1;
      t1 = cyc;
    end
    if (rd_dp) check("hrdata", hrdata, exp_q.pop_front());
    rd_dp <= hsel && htrans[1] && !hwrite;
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic conclude();
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      conclude();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  initial begin
    repeat (50000) @(posedge hclk);
    n_errors++;
    conclude();
  end

  initial begin
    int i;
    int ns;
    logic [1:0] ep, eg;
    logic [11:0] a;
    logic [31:0] v;
    i = $urandom(32'hC3AB5907);
    ep = 2'h0;
    eg = 2'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("dac_n", dac_n, 32'h3FF);
    rd(`TABC_OFF_ADC_CTRL, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = {23'h0, i[0], i[1:0], i[0], i[1:0], 1'b1, i[1:0]};
      wr(`TABC_OFF_COND, v);
      if (i != 3) begin
        ep = i[1:0];
        eg = i[1:0];
      end
      rd(`TABC_OFF_COND, {23'h0, i[0], eg, i[0], ep, 1'b1, ep});
      check("gain", cond.gain, eg);
      check("bypass", cond.filter_bypass, i[0]);
    end
    wr(`TABC_OFF_ADC_CTRL, 32'h28);
    repeat (50) @(posedge hclk);
    check("hiz", cond.drive_high_impedance, 1'b1);
    check("samples_off", n_samp, 0);
    a = 12'($urandom);
    level <= a;
    ns = n_samp;
    wr(`TABC_OFF_ADC_CTRL, 32'h40);
    wr(`TABC_OFF_ADC_CTRL, 32'h50);
    @(posedge hclk);
    rd(`TABC_OFF_ADC_CTRL, 32'h140);
    wr(`TABC_OFF_ADC_CTRL, 32'h50);
    repeat (20) @(posedge hclk);
    check("one_conv", n_samp, ns + 1);
    rd(`TABC_OFF_ADC_CTRL, 32'h240);
    rd(`TABC_OFF_RES_HI, {28'h0, a[11:8]});
    rd(`TABC_OFF_RES_LO, {24'h0, a[7:0]});
    rd(`TABC_OFF_ADC_CTRL, 32'h40);
    wr(`TABC_OFF_ADC_CTRL, 32'h48);
    repeat (40) @(posedge hclk);
    rd(`TABC_OFF_RES_HI, {28'h0, a[11:8]});
    level <= ~a;
    repeat (40) @(posedge hclk);
    rd(`TABC_OFF_RES_LO, {24'h0, a[7:0]});
    rd(`TABC_OFF_RES_HI, {28'h0, ~a[11:8]});
    rd(`TABC_OFF_RES_LO, {24'h0, ~a[7:0]});
    for (i = 2; i < 4; i++) begin
      wr(`TABC_OFF_ADC_CTRL, 32'h48 | i);
      repeat (100) @(posedge hclk);
      check("interval", t1 - t0, BASE << i);
    end
    wr(`TABC_OFF_ADC_CTRL, 32'h0);
    for (i = 0; i < 2; i++) begin
      v = $urandom;
      cmp_bits <= v[7:0];
      fix_in <= v[15:8];
      wr(`TABC_OFF_BL_CTRL, {27'h0, i[0], 1'b1, v[18:16]});
      wr(`TABC_OFF_BL_DAC, {24'h0, v[31:24]});
      rd(`TABC_OFF_BL_DAC, {24'h0, v[31:24]});
      rd(`TABC_OFF_BL_STAT, {24'h0, v[7:0]});
      check("position", bl.position, v[18:16]);
      check("bl_code", bl.threshold_code, v[31:24]);
      check("ext_sel", bl.external_threshold_select, i[0]);
      check("sw_en", bl.threshold_switch_enable, 1'b1);
      check("fixed", fix_out, v[15:8]);
    end
    wr(`TABC_OFF_BL_CTRL, 32'h0);
    @(posedge hclk);
    check("sw_en_off", bl.threshold_switch_enable, 1'b0);
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'h0 : (i == 1) ? 32'h3FF : {22'h0, 10'($urandom)};
      wr(`TABC_OFF_IDAC, v);
      rd(`TABC_OFF_IDAC, v);
      check("dac", dac, v);
      check("dac_n", dac_n, 32'h3FF - v);
    end
    v = $urandom;
    trim_def <= ~v;
    wr(`TABC_OFF_TRIM, v);
    wr(`TABC_OFF_TRIM_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    check("trim_ovr", trim_val, v);
    rd(`TABC_OFF_TRIM, v);
    wr(`TABC_OFF_TRIM_CTRL, 32'h3);
    rd(`TABC_OFF_TRIM, trim_def);
    wr(`TABC_OFF_TRIM_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    check("trim_def", trim_val, trim_def);
    rd(`TABC_OFF_TRIM, trim_def);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    repeat (3) @(posedge hclk);
    conclude();
  end
endmodule : telemetry_adc_bilevel_ctrl_bench

bind tabc_ctrl tabc_ctrl_assertions #(.ADC_W(ADC_W)) u_tabc_ctrl_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sar_sample(sar_sample),
  .sar_trial_code(sar_trial_code), .cond(cond), .bl(bl), .fixed_comparator_in(fixed_comparator_in),
  .fixed_comparator_output(fixed_comparator_output), .current_dac_code(current_dac_code),
  .current_dac_code_n(current_dac_code_n));
